/* File: common/mfr_pkg.sv */
// Shared constants and types for the measurement setup command decoder
package mfr_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int NUM_FUNCS = 4;
    localparam int RANGE_W   = 3;
    localparam int INTEGRATION_LINE_CYCLES_W    = 8;
    localparam int ERR_W     = 2;
    localparam int CNT_W     = 8;

    // ************************************************************
    // Measurement functions
    // ************************************************************
    typedef enum logic [1:0] {
        dc_volts_function      = 2'h0,
        dc_amps_function       = 2'h1,
        two_wire_ohms_function = 2'h2,
        four_wire_ohms_function = 2'h3
    } mfr_func_t;

    // ************************************************************
    // Command operations
    // ************************************************************
    typedef enum logic [2:0] {
        op_select_function = 3'h0,
        op_range_code      = 3'h1,
        op_set_range       = 3'h2,
        op_set_integration_line_cycles        = 3'h3,
        op_set_autorange   = 3'h4,
        op_set_autozero    = 3'h5,
        op_module_reset    = 3'h6
    } mfr_op_t;

    typedef enum logic [1:0] {
        az_off  = 2'h0,
        az_on   = 2'h1,
        az_once = 2'h2
    } mfr_az_t;

    // ************************************************************
    // Range codes and error codes
    // ************************************************************
    localparam logic [RANGE_W-1:0] range_code_one   = 3'h1;
    localparam logic [RANGE_W-1:0] range_code_two   = 3'h2;
    localparam logic [RANGE_W-1:0] range_code_three = 3'h3;
    localparam logic [RANGE_W-1:0] range_code_four  = 3'h4;
    localparam logic [RANGE_W-1:0] range_code_five  = 3'h5;
    localparam logic [RANGE_W-1:0] range_code_six   = 3'h6;
    localparam logic [RANGE_W-1:0] range_code_seven = 3'h7;

    localparam logic [ERR_W-1:0] ERR_NONE         = 2'h0;
    localparam logic [ERR_W-1:0] ERR_OUT_OF_RANGE = 2'h1;
    localparam logic [ERR_W-1:0] ERR_INVALID      = 2'h2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [RANGE_W-1:0] PON_VOLTS_RANGE = range_code_three;
    localparam logic [RANGE_W-1:0] RST_VOLTS_RANGE = range_code_five;
    localparam logic [RANGE_W-1:0] DEF_AMPS_RANGE  = range_code_three;
    localparam logic [RANGE_W-1:0] DEF_OHMS_RANGE  = range_code_two;
    localparam logic [INTEGRATION_LINE_CYCLES_W-1:0]  DEF_INTEGRATION_LINE_CYCLES        = 8'h0a;
    localparam logic               DEF_AUTORANGE   = 1'b1;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 100;
    localparam int RECONFIG_TIME_NS = 1000;
    localparam int RECONFIG_CYCLES  =
        (RECONFIG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : mfr_pkg

/* File: rtl/mfr_range_decode.sv */
// Range code legality check per measurement function
`timescale 1ns/10ps
module mfr_range_decode
    import mfr_pkg::*;
(
    // Request
    input  wire mfr_func_t            func,
    input  wire logic [RANGE_W-1:0]   code,
    // Verdict
    output logic                      range_ok,
    output logic [ERR_W-1:0]          range_err
);

    always_comb
    begin
        range_ok  = 1'b0;
        range_err = ERR_INVALID;
        unique case (func)
            dc_volts_function:
            begin
                if (code >= range_code_one && code <= range_code_five)
                begin
                    range_ok  = 1'b1;
                    range_err = ERR_NONE;
                end
                else
                    range_err = ERR_INVALID;
            end
            dc_amps_function:
            begin
                if (code >= range_code_one && code <= range_code_four)
                begin
                    range_ok  = 1'b1;
                    range_err = ERR_NONE;
                end
                else if (code >= range_code_five)
                    range_err = ERR_OUT_OF_RANGE;
                else
                    range_err = ERR_INVALID;
            end
            two_wire_ohms_function, four_wire_ohms_function:
            begin
                if (code >= range_code_one)
                begin
                    range_ok  = 1'b1;
                    range_err = ERR_NONE;
                end
            end
        endcase
    end

endmodule : mfr_range_decode

/* File: rtl/mfr_autozero_seq.sv */
// Converter sequencer: zero and signal conversions per autozero mode
`timescale 1ns/10ps
module mfr_autozero_seq
    import mfr_pkg::*;
(
    // Clock and reset
    input  wire logic    clock,
    input  wire logic    reset_n,
    // Control
    input  wire mfr_az_t mode,
    input  wire logic    once_req,
    input  wire logic    scan_req,
    // Converter
    input  wire logic    conv_done,
    output logic         conv_start,
    output logic         conv_zero,
    output logic         seq_ready
);

    typedef enum logic [2:0] {
        sq_idle   = 3'b001,
        sq_zero   = 3'b010,
        sq_signal = 3'b100
    } mfr_sq_t;

    typedef struct packed {
        mfr_sq_t st;
        logic    start;
        logic    zero;
        logic    pend_signal;
        logic    once_pend;
    } mfr_seq_t;

    mfr_seq_t s_r;
    mfr_seq_t s_nxt;

    always_comb
    begin
        s_nxt       = s_r;
        s_nxt.start = 1'b0;
        if (once_req)
            s_nxt.once_pend = 1'b1;
        unique case (s_r.st)
            sq_idle:
            begin
                if (s_r.once_pend || once_req)
                begin
                    s_nxt.st          = sq_zero;
                    s_nxt.start       = 1'b1;
                    s_nxt.zero        = 1'b1;
                    s_nxt.pend_signal = 1'b0;
                    s_nxt.once_pend   = 1'b0;
                end
                else if (scan_req && mode == az_on)
                begin
                    s_nxt.st          = sq_zero;
                    s_nxt.start       = 1'b1;
                    s_nxt.zero        = 1'b1;
                    s_nxt.pend_signal = 1'b1;
                end
                else if (scan_req)
                begin
                    s_nxt.st    = sq_signal;
                    s_nxt.start = 1'b1;
                    s_nxt.zero  = 1'b0;
                end
            end
            sq_zero:
            begin
                if (conv_done && s_r.pend_signal)
                begin
                    s_nxt.st          = sq_signal;
                    s_nxt.start       = 1'b1;
                    s_nxt.zero        = 1'b0;
                    s_nxt.pend_signal = 1'b0;
                end
                else if (conv_done)
                begin
                    s_nxt.st   = sq_idle;
                    s_nxt.zero = 1'b0;
                end
            end
            sq_signal:
            begin
                if (conv_done)
                    s_nxt.st = sq_idle;
            end
            default: s_nxt.st = sq_idle;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            s_r <= '{st: sq_idle, default: '0};
        else
            s_r <= s_nxt;
    end

    assign conv_start = s_r.start;
    assign conv_zero  = s_r.zero;
    assign seq_ready  = (s_r.st == sq_idle) && !s_r.once_pend;

endmodule : mfr_autozero_seq

/* File: rtl/mfr_setup_decoder.sv */
// Measurement setup command decoder with per-function range state
//
// Operation
// - Four function codes select volts, amps, ohms
// - Range code affects active function only
// - Volts codes one to five: 0.1-300 V
// - Amps codes one to four; zero invalid
// - Ohms codes one to seven: 100-100E6
// - Codes six, seven invalid for volts
// - Amps codes five to seven: out-of-range error
// - Range stored per function, others unchanged
// - Two- and four-wire ohms ranges linked
// - Reselected function restores its last state
// - Function/range codes keep integration setting
// - Power-on selects DC volts
// - Module reset: volts 300 V, rest power-on
// - Function change reconfigures hardware before measuring
// - Autozero on: zero before each measurement
// - Autozero off: no new zero readings
// - Autozero once: one zero, then off
// - Explicit range turns that function's autorange off
// - Per-function autorange, queryable and settable
// - Early external trigger ignored, no error
`timescale 1ns/10ps
module mfr_setup_decoder
    import mfr_pkg::*;
#(
    parameter int RECONF_CYCLES = RECONFIG_CYCLES
)
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                reset_n,
    // Command port
    input  wire logic                cmd_valid,
    output logic                     cmd_ready,
    input  wire mfr_op_t             cmd_op,
    input  wire mfr_func_t           cmd_func,
    input  wire logic [RANGE_W-1:0]  cmd_range,
    input  wire logic [INTEGRATION_LINE_CYCLES_W-1:0]   cmd_integration_line_cycles,
    input  wire logic                cmd_flag,
    input  wire mfr_az_t             cmd_az,
    // Error report
    output logic                     err_valid,
    output logic [ERR_W-1:0]         err_code,
    // Active setup
    output mfr_func_t                active_func,
    output logic [RANGE_W-1:0]       active_range,
    output logic [INTEGRATION_LINE_CYCLES_W-1:0]        active_integration_line_cycles,
    output logic                     active_autorange,
    output mfr_az_t                  autozero_mode,
    output logic                     reconfig_busy,
    // Query port
    input  wire mfr_func_t           query_func,
    output logic [RANGE_W-1:0]       query_range,
    output logic [INTEGRATION_LINE_CYCLES_W-1:0]        query_integration_line_cycles,
    output logic                     query_autorange,
    // Trigger and converter
    input  wire logic                ext_trigger,
    output logic                     scan_ready,
    input  wire logic                conv_done,
    output logic                     conv_start,
    output logic                     conv_zero
);

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {
        st_idle     = 2'b01,
        st_reconfig = 2'b10
    } mfr_state_t;

    typedef struct packed {
        mfr_state_t                          fsm;
        mfr_func_t                           func;
        logic [NUM_FUNCS-1:0][RANGE_W-1:0]   range;
        logic [NUM_FUNCS-1:0][INTEGRATION_LINE_CYCLES_W-1:0]    integration_line_cycles;
        logic [NUM_FUNCS-1:0]                autorange;
        mfr_az_t                             az_mode;
        logic                                az_once;
        logic [CNT_W-1:0]                    cnt;
        logic                                err_valid;
        logic [ERR_W-1:0]                    err_code;
        logic [2:0]                          trig_sync;
        logic                                scan_go;
        logic [RANGE_W-1:0]                  q_range;
        logic [INTEGRATION_LINE_CYCLES_W-1:0]                   q_integration_line_cycles;
        logic                                q_auto;
    } mfr_regs_t;

    localparam logic [CNT_W-1:0] RECONF_LAST = CNT_W'(RECONF_CYCLES - 1);

    mfr_regs_t r_r;
    mfr_regs_t r_nxt;

    mfr_func_t          dec_func;
    logic [RANGE_W-1:0] dec_code;
    logic               dec_ok;
    logic [ERR_W-1:0]   dec_err;
    logic               seq_ready;
    logic               cmd_take;
    logic               trig_edge;
    logic               ready_for_scan;

    // ************************************************************
    // Range legality and converter sequencing
    // ************************************************************
    // Short range codes target the active function, explicit ones name it
    assign dec_func = (cmd_op == op_range_code) ? r_r.func : cmd_func;
    assign dec_code = cmd_range;

    mfr_range_decode u_range_decode (
        .func      (dec_func),
        .code      (dec_code),
        .range_ok  (dec_ok),
        .range_err (dec_err)
    );

    mfr_autozero_seq u_autozero_seq (
        .clock      (clock),
        .reset_n    (reset_n),
        .mode       (r_r.az_mode),
        .once_req   (r_r.az_once),
        .scan_req   (r_r.scan_go),
        .conv_done  (conv_done),
        .conv_start (conv_start),
        .conv_zero  (conv_zero),
        .seq_ready  (seq_ready)
    );

    // One command at a time; the next waits until this one took effect
    assign cmd_ready = (r_r.fsm == st_idle);
    assign cmd_take  = cmd_valid && cmd_ready;

    // Edge seen only on the second and third sync stages
    assign trig_edge = r_r.trig_sync[1] && !r_r.trig_sync[2];

    // Not ready while reconfiguring or converting; no scan queued either
    assign ready_for_scan = (r_r.fsm == st_idle) && seq_ready &&
                            !r_r.scan_go && !r_r.az_once;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        r_nxt           = r_r;
        r_nxt.err_valid = 1'b0;
        r_nxt.err_code  = ERR_NONE;
        r_nxt.az_once   = 1'b0;
        r_nxt.scan_go   = 1'b0;

        // Trigger synchroniser
        r_nxt.trig_sync = {r_r.trig_sync[1:0], ext_trigger};

        // A trigger that finds the block busy is dropped silently
        if (trig_edge && ready_for_scan)
            r_nxt.scan_go = 1'b1;

        // Query answers registered one cycle after the request
        r_nxt.q_range = r_r.range[query_func];
        r_nxt.q_integration_line_cycles  = r_r.integration_line_cycles[query_func];
        r_nxt.q_auto  = r_r.autorange[query_func];

        unique case (r_r.fsm)
            st_idle:
            begin
                if (cmd_take)
                begin
                    unique case (cmd_op)
                        op_select_function:
                        begin
                            // Ranges live per function, so reselecting
                            // simply brings the old one back
                            r_nxt.func = cmd_func;
                            if (cmd_func != r_r.func)
                            begin
                                r_nxt.fsm = st_reconfig;
                                r_nxt.cnt = '0;
                            end
                        end
                        op_range_code, op_set_range:
                        begin
                            if (dec_ok)
                            begin
                                r_nxt.range[dec_func]     = cmd_range;
                                r_nxt.autorange[dec_func] = 1'b0;
                                if (dec_func == two_wire_ohms_function ||
                                    dec_func == four_wire_ohms_function)
                                begin
                                    r_nxt.range[two_wire_ohms_function]
                                        = cmd_range;
                                    r_nxt.range[four_wire_ohms_function]
                                        = cmd_range;
                                    r_nxt.autorange[two_wire_ohms_function]
                                        = 1'b0;
                                    r_nxt.autorange[four_wire_ohms_function]
                                        = 1'b0;
                                end
                            end
                            else
                            begin
                                r_nxt.err_valid = 1'b1;
                                r_nxt.err_code  = dec_err;
                            end
                        end
                        op_set_integration_line_cycles:
                        begin
                            r_nxt.integration_line_cycles[cmd_func] = cmd_integration_line_cycles;
                        end
                        op_set_autorange:
                        begin
                            r_nxt.autorange[cmd_func] = cmd_flag;
                        end
                        op_set_autozero:
                        begin
                            if (cmd_az == az_once)
                            begin
                                r_nxt.az_mode = az_off;
                                r_nxt.az_once = 1'b1;
                            end
                            else
                                r_nxt.az_mode = cmd_az;
                        end
                        op_module_reset:
                        begin
                            r_nxt.func = dc_volts_function;
                            r_nxt.range[dc_volts_function] =
                                RST_VOLTS_RANGE;
                            r_nxt.range[dc_amps_function] = DEF_AMPS_RANGE;
                            r_nxt.range[two_wire_ohms_function] =
                                DEF_OHMS_RANGE;
                            r_nxt.range[four_wire_ohms_function] =
                                DEF_OHMS_RANGE;
                            for (int i = 0; i < NUM_FUNCS; i++)
                                r_nxt.integration_line_cycles[i] = DEF_INTEGRATION_LINE_CYCLES;
                            r_nxt.autorange = {NUM_FUNCS{DEF_AUTORANGE}};
                            r_nxt.az_mode   = az_on;
                            if (r_r.func != dc_volts_function)
                            begin
                                r_nxt.fsm = st_reconfig;
                                r_nxt.cnt = '0;
                            end
                        end
                        default:
                        begin
                            r_nxt.err_valid = 1'b1;
                            r_nxt.err_code  = ERR_INVALID;
                        end
                    endcase
                end
            end
            st_reconfig:
            begin
                // Front end settles before any new scan is accepted
                if (r_r.cnt == RECONF_LAST)
                    r_nxt.fsm = st_idle;
                else
                    r_nxt.cnt = r_r.cnt + CNT_W'(1);
            end
            default: r_nxt.fsm = st_idle;
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            r_r.fsm       <= st_idle;
            r_r.func      <= dc_volts_function;
            r_r.range[dc_volts_function]       <= PON_VOLTS_RANGE;
            r_r.range[dc_amps_function]        <= DEF_AMPS_RANGE;
            r_r.range[two_wire_ohms_function]  <= DEF_OHMS_RANGE;
            r_r.range[four_wire_ohms_function] <= DEF_OHMS_RANGE;
            r_r.integration_line_cycles      <= {NUM_FUNCS{DEF_INTEGRATION_LINE_CYCLES}};
            r_r.autorange <= {NUM_FUNCS{DEF_AUTORANGE}};
            r_r.az_mode   <= az_on;
            r_r.az_once   <= 1'b0;
            r_r.cnt       <= '0;
            r_r.err_valid <= 1'b0;
            r_r.err_code  <= ERR_NONE;
            r_r.trig_sync <= 3'h0;
            r_r.scan_go   <= 1'b0;
            r_r.q_range   <= '0;
            r_r.q_integration_line_cycles    <= '0;
            r_r.q_auto    <= 1'b0;
        end
        else
            r_r <= r_nxt;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign err_valid        = r_r.err_valid;
    assign err_code         = r_r.err_code;
    assign active_func      = r_r.func;
    assign active_range     = r_r.range[r_r.func];
    assign active_integration_line_cycles      = r_r.integration_line_cycles[r_r.func];
    assign active_autorange = r_r.autorange[r_r.func];
    assign autozero_mode    = r_r.az_mode;
    assign reconfig_busy    = (r_r.fsm == st_reconfig);
    assign query_range      = r_r.q_range;
    assign query_integration_line_cycles       = r_r.q_integration_line_cycles;
    assign query_autorange  = r_r.q_auto;
    assign scan_ready       = ready_for_scan;

endmodule : mfr_setup_decoder

/* File: testbench/mfr_setup_props.sv */
// Port checks for the setup decoder
`timescale 1ns/10ps
module mfr_setup_props
    import mfr_pkg::*;
(
    // Clock, reset, command
    input wire logic               clock,
    input wire logic               reset_n,
    input wire logic               cmd_valid,
    input wire logic               cmd_ready,
    input wire mfr_op_t            cmd_op,
    input wire mfr_func_t          cmd_func,
    input wire logic [RANGE_W-1:0] cmd_range,
    input wire mfr_az_t            cmd_az,
    // Outputs
    input wire logic               err_valid,
    input wire logic [ERR_W-1:0]   err_code,
    input wire mfr_func_t          active_func,
    input wire logic [RANGE_W-1:0] active_range,
    input wire logic [INTEGRATION_LINE_CYCLES_W-1:0]  active_integration_line_cycles,
    input wire logic               active_autorange,
    input wire mfr_az_t            autozero_mode,
    input wire logic               reconfig_busy
);
    wire tk = cmd_valid && cmd_ready;
    wire rc = tk && cmd_op == op_range_code;
    wire amp = active_func == dc_amps_function;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_err_pulse:
    assert property (err_valid |-> $past(tk)) else $error("stray error");
    a_amps_err:
    assert property (rc && amp && cmd_range >= range_code_five
        |=> err_valid && err_code == ERR_OUT_OF_RANGE) else $error("amps");
    a_volts_err:
    assert property (rc && active_func == dc_volts_function &&
        cmd_range >= range_code_six |=> err_valid && err_code == ERR_INVALID)
        else $error("volts code");
    a_range_kept:
    assert property (rc && amp && cmd_range >= range_code_five
        |=> $stable(active_range)) else $error("range moved");
    a_ohms_range:
    assert property (rc && active_func[1] && cmd_range != 3'h0 |=>
        active_range == $past(cmd_range) && !active_autorange)
        else $error("ohms range");
    a_integration_line_cycles_kept:
    assert property (rc |=> $stable(active_integration_line_cycles)) else $error("integration_line_cycles moved");
    a_func_busy:
    assert property (tk && cmd_op == op_select_function &&
        cmd_func != active_func |=> reconfig_busy && !cmd_ready &&
        active_func == $past(cmd_func)) else $error("no reconfig");
    a_once_off:
    assert property (tk && cmd_op == op_set_autozero && cmd_az == az_once
        |=> autozero_mode == az_off) else $error("once mode");
    cover property (rc && active_func == four_wire_ohms_function);
    cover property (err_valid);
    cover property ($fell(reconfig_busy));
endmodule : mfr_setup_props

/* File: testbench/mfr_conv_model.sv */
// Converter stand-in: a done pulse a few cycles after each start
`timescale 1ns/10ps
module mfr_conv_model
(
    // Converter handshake
    input  wire logic clock,
    input  wire logic conv_start,
    output logic      conv_done = 1'b0
);
    logic [2:0] cnt_r = 3'h0;
    always_ff @(posedge clock)
    begin
        conv_done <= (cnt_r == 3'h1);
        cnt_r <= conv_start ? 3'h4 : cnt_r - (cnt_r != 3'h0);
    end
endmodule : mfr_conv_model

/* File: testbench/test_meter_fast_function_range_cmds.sv */
// Bench for the setup decoder
`timescale 1ns/10ps
module test_meter_fast_function_range_cmds
    import mfr_pkg::*;
;
    logic clock = 0, reset_n = 0, cmd_valid = 0, cmd_flag = 0, ext_trigger = 0;
    logic [2:0] cmd_range = 0, active_range, query_range;
    logic [7:0] cmd_integration_line_cycles = 0, active_integration_line_cycles, query_integration_line_cycles;
    mfr_op_t cmd_op = op_range_code;
    mfr_func_t cmd_func = dc_volts_function, query_func = dc_volts_function;
    mfr_func_t active_func;
    mfr_az_t cmd_az = az_on, autozero_mode;
    logic [1:0] err_code;
    logic cmd_ready, err_valid, active_autorange, reconfig_busy, scan_ready;
    logic query_autorange, conv_done, conv_start, conv_zero;
    int n_fail = 0, n_checks = 0;
    mfr_setup_decoder #(.RECONF_CYCLES(2)) dut (.*);
    mfr_conv_model u_conv (.clock, .conv_start, .conv_done);
    always #50 clock = ~clock;
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Request held until taken, results read half a cycle later
    task automatic cmd(mfr_op_t o, mfr_func_t f, logic [2:0] r, logic [7:0] n);
        @(posedge clock);
        cmd_op    <= o;
        cmd_func  <= f;
        {cmd_range, cmd_integration_line_cycles, cmd_flag} <= {r, n, r[0]};
        cmd_az    <= mfr_az_t'(r[1:0]);
        cmd_valid <= 1'b1;
        @(negedge clock);
        while (!cmd_ready) @(negedge clock);
        @(posedge clock);
        cmd_valid <= 1'b0;
        @(negedge clock);
    endtask : cmd
    task automatic q(mfr_func_t f, logic [2:0] r, logic [7:0] n);
        @(posedge clock);
        query_func <= f;
        repeat (2) @(posedge clock);
        chk(query_range, r);
        chk(query_integration_line_cycles, n);
    endtask : q
    task automatic wstart(logic z);
        for (int i = 0; i < 40 && !conv_start; i++) @(negedge clock);
        chk(conv_start, 1);
        chk(conv_zero, z);
    endtask : wstart
    task automatic trig(logic z);
        while (!scan_ready) @(negedge clock);
        @(posedge clock);
        ext_trigger <= 1'b1;
        wstart(z);
        @(posedge clock);
        ext_trigger <= 1'b0;
        // Let the start pulse of this edge settle before looking again
        @(negedge clock);
    endtask : trig
    task automatic t_ranges;
        chk(active_func, dc_volts_function);
        chk(active_range, 3'h3);
        q(four_wire_ohms_function, 3'h2, 8'h0a);
        for (int i = 1; i < 7; i++)
        begin
            cmd(op_range_code, dc_volts_function, 3'(i), 8'h0);
            chk(active_range, i < 6 ? i : 5);
            chk(err_code, i < 6 ? 0 : 2);
        end
        chk(active_autorange, 0);
        cmd(op_select_function, dc_amps_function, 3'h0, 8'h0);
        chk(reconfig_busy, 1);
        chk(active_range, 3'h3);
        for (int i = 4; i < 8; i++)
        begin
            cmd(op_range_code, dc_amps_function, 3'(i), 8'h0);
            chk(active_range, 3'h4);
            chk(err_code, i < 5 ? 0 : 1);
            chk(err_valid, i > 4);
        end
    endtask : t_ranges
    task automatic t_ohms;
        cmd(op_select_function, two_wire_ohms_function, 3'h7, 8'h0);
        cmd(op_range_code, two_wire_ohms_function, 3'h7, 8'h0);
        cmd(op_select_function, four_wire_ohms_function, 3'h0, 8'h0);
        chk(active_range, 3'h7);
        cmd(op_set_integration_line_cycles, four_wire_ohms_function, 3'h0, 8'h05);
        cmd(op_range_code, four_wire_ohms_function, 3'h1, 8'h0);
        chk(active_integration_line_cycles, 8'h05);
        q(two_wire_ohms_function, 3'h1, 8'h0a);
        chk(query_autorange, 0);
        cmd(op_set_autorange, four_wire_ohms_function, 3'h1, 8'h0);
        chk(active_autorange, 1);
        cmd(op_select_function, dc_volts_function, 3'h0, 8'h0);
        chk(active_range, 3'h5);
        cmd(op_range_code, dc_volts_function, 3'h1, 8'h0);
        cmd(op_module_reset, dc_volts_function, 3'h0, 8'h0);
        chk(active_range, 3'h5);
        chk(active_autorange, 1);
        q(dc_amps_function, 3'h3, 8'h0a);
        q(four_wire_ohms_function, 3'h2, 8'h0a);
        chk(query_autorange, 1);
    endtask : t_ohms
    task automatic t_zero;
        trig(1);
        wstart(0);
        cmd(op_set_autozero, dc_volts_function, 3'h2, 8'h0);
        chk(autozero_mode, az_off);
        wstart(1);
        trig(0);
    endtask : t_zero
    task automatic print_verdict;
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        t_ranges();
        t_ohms();
        t_zero();
        print_verdict();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        #400000;
        n_fail++;
        print_verdict();
    end
endmodule : test_meter_fast_function_range_cmds
bind mfr_setup_decoder mfr_setup_props u_props (.*);
